// ==== rtl/bit_op_pkg.sv ====
package bit_op_pkg;

	// Width of one instruction word and of its fields.
	localparam int INSTR_W  = 14;
	localparam int OPCODE_W = 4;
	localparam int ADDR_W   = 7;
	localparam int BITSEL_W = 3;
	localparam int DATA_W   = 8;

	// Field positions inside the instruction word.
	localparam int ADDR_LSB   = 0;
	localparam int BITSEL_LSB = 7;
	localparam int OPCODE_LSB = 10;

	// Upper four bits of the word select the bit-oriented operation.
	localparam logic [OPCODE_W-1:0] OPC_CLEAR = 4'h4;
	localparam logic [OPCODE_W-1:0] OPC_SET   = 4'h5;
	localparam logic [OPCODE_W-1:0] OPC_TEST  = 4'h6;

	// Reset values of the datapath registers.
	localparam logic [ADDR_W-1:0]   ADDR_RST   = 7'h00;
	localparam logic [BITSEL_W-1:0] BITSEL_RST = 3'h0;
	localparam logic [DATA_W-1:0]   DATA_RST   = 8'h00;

	// Single set bit that is shifted to form a bit mask.
	localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;

	// Quarter phases of one instruction cycle, Gray coded along the ring.
	typedef enum logic [1:0]
	{
		q1 = 2'h0,
		q2 = 2'h1,
		q3 = 2'h3,
		q4 = 2'h2
	} phase_t;

	// Operation held for the current instruction cycle.
	typedef enum logic [2:0]
	{
		op_none                  = 3'h0,
		clear_bit_op             = 3'h1,
		set_bit_op               = 3'h2,
		test_bit_skip_if_zero_op = 3'h3,
		idle_slot                = 3'h4
	} op_t;

	// Instruction word split into its fields.
	typedef struct packed
	{
		logic [OPCODE_W-1:0] opcode;
		logic [BITSEL_W-1:0] bitsel;
		logic [ADDR_W-1:0]   addr;
	} instr_fields_t;

endpackage

// ==== rtl/bit_modify.sv ====
`timescale 1ns/1ps

// Combinational bit operator: clears, sets or tests one selected bit.
module bit_modify
	import bit_op_pkg::*;
#(
	parameter int WIDTH = DATA_W
)
(
	// Operand and selection.
	input  wire logic [WIDTH-1:0]    data,
	input  wire logic [BITSEL_W-1:0] bitsel,
	input  wire op_t                 op,
	// Results.
	output logic      [WIDTH-1:0]    result,
	output logic                     tested_bit
);

	// The selector must be able to reach every bit and no more, so a wrong width is refused at elaboration.
	if (WIDTH != (1 << BITSEL_W))
	begin : g_width_check
		$error("bit_modify: WIDTH must equal two to the power of BITSEL_W.");
	end

	logic [WIDTH-1:0] mask;  // One-hot mask of the selected bit.

	// Only the selected bit changes; all others pass straight through.
	always_comb
	begin
		mask       = WIDTH'(BIT_ONE) << bitsel;
		tested_bit = data[bitsel];
		case (op)
			clear_bit_op: result = data & ~mask;
			set_bit_op:   result = data | mask;
			default:      result = data;
		endcase
	end

endmodule

// ==== rtl/bit_op_instruction_unit.sv ====
`timescale 1ns/1ps

module bit_op_instruction_unit
	import bit_op_pkg::*;
(
	// Clock and synchronous active-low reset.
	input  wire logic                clk,
	input  wire logic                resetn,
	// Instruction stream, sampled in the first quarter.
	input  wire instr_fields_t       instr,
	input  wire logic                instr_valid,
	// Register file read side.
	output logic      [ADDR_W-1:0]   rf_addr,
	output logic                     rf_re,
	input  wire logic [DATA_W-1:0]   rf_rdata,
	// Register file write side.
	output logic                     rf_we,
	output logic      [DATA_W-1:0]   rf_wdata,
	// Status register write strobe for the flags.
	output logic                     status_we,
	// Sequencing observation.
	output phase_t                   phase,
	output logic                     instr_taken,
	output logic                     slot_discarded,
	output logic                     skip_pending
);

	op_t                 op;            // Operation of the running cycle.
	logic [BITSEL_W-1:0] bitsel;        // Selected bit of the running cycle.
	logic [DATA_W-1:0]   data;          // Register value read in the second quarter.
	phase_t              next_phase;    // Next quarter phase.
	op_t                 next_op;       // Next operation.
	logic [ADDR_W-1:0]   next_addr;     // Next register address.
	logic [BITSEL_W-1:0] next_bitsel;   // Next bit selector.
	logic [DATA_W-1:0]   next_data;     // Next read data.
	logic [DATA_W-1:0]   next_wdata;    // Next write data.
	logic                next_skip;     // Next skip request.
	logic [DATA_W-1:0]   modified;      // Read data after the bit operation.
	logic                tested_bit;    // Value of the selected bit.
	logic                is_bit_op;     // The running cycle touches the register file.
	logic                is_write_op;   // The running cycle writes the register back.

	// Shared bit operator for clear, set and test.
	bit_modify #(
		.WIDTH      (DATA_W)
	) u_bit_modify (
		.data       (data),
		.bitsel     (bitsel),
		.op         (op),
		.result     (modified),
		.tested_bit (tested_bit)
	);

	// Classify the operation held for this cycle.
	always_comb
	begin
		is_write_op = (op == clear_bit_op) || (op == set_bit_op);
		is_bit_op   = is_write_op || (op == test_bit_skip_if_zero_op);
	end

	// Next-state logic of the quarter sequencer and datapath.
	always_comb
	begin
		next_phase  = phase;
		next_op     = op;
		next_addr   = rf_addr;
		next_bitsel = bitsel;
		next_data   = data;
		next_wdata  = rf_wdata;
		next_skip   = skip_pending;
		case (phase)
			q1:
			begin
				// Decode quarter; a pending skip replaces the fetched word.
				next_phase = q2;
				if (skip_pending)
				begin
					next_op   = idle_slot;
					next_skip = 1'b0;
				end
				else if (instr_valid)
				begin
					next_addr   = instr.addr;
					next_bitsel = instr.bitsel;
					case (instr.opcode)
						OPC_CLEAR: next_op = clear_bit_op;
						OPC_SET:   next_op = set_bit_op;
						OPC_TEST:  next_op = test_bit_skip_if_zero_op;
						default:   next_op = op_none;
					endcase
				end
				else
				begin
					next_op = op_none;
				end
			end
			q2:
			begin
				// Read quarter; the register file answers in the same cycle.
				next_phase = q3;
				if (is_bit_op)
					next_data = rf_rdata;
			end
			q3:
			begin
				// Modify quarter; a zero test bit arms the skip.
				next_phase = q4;
				next_wdata = modified;
				if ((op == test_bit_skip_if_zero_op) && !tested_bit)
					next_skip = 1'b1;
			end
			q4:
			begin
				// Write quarter; the test instruction writes nothing here.
				next_phase = q1;
			end
			default:
			begin
				next_phase = q1;
			end
		endcase
	end

	// Register the sequencer and datapath state.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			phase        <= q1;
			op           <= op_none;
			rf_addr      <= ADDR_RST;
			bitsel       <= BITSEL_RST;
			data         <= DATA_RST;
			rf_wdata     <= DATA_RST;
			skip_pending <= 1'b0;
		end
		else
		begin
			phase        <= next_phase;
			op           <= next_op;
			rf_addr      <= next_addr;
			bitsel       <= next_bitsel;
			data         <= next_data;
			rf_wdata     <= next_wdata;
			skip_pending <= next_skip;
		end
	end

	// Strobes other than status_we are decoded from the phase so they last exactly one quarter.
	always_comb
	begin
		instr_taken    = (phase == q1) && instr_valid && !skip_pending;
		rf_re          = (phase == q2) && is_bit_op;
		rf_we          = (phase == q4) && is_write_op;
		slot_discarded = (phase == q4) && (op == idle_slot);
		// Flags stay as they were; the strobe is kept so a wider core can merge it.
		status_we      = 1'b0;
	end

	// Clear writes back the read value with only the selected bit dropped.
	a_clear_bit_only: assert property (@(posedge clk) disable iff (!resetn)
		(rf_we && op == clear_bit_op) |-> (rf_wdata == (data & ~(BIT_ONE << bitsel))))
		else $error("Clear wrote a wrong value.");

	// Set writes back the read value with only the selected bit raised.
	a_set_bit_only: assert property (@(posedge clk) disable iff (!resetn)
		(rf_we && op == set_bit_op) |-> (rf_wdata == (data | (BIT_ONE << bitsel))))
		else $error("Set wrote a wrong value.");

	// A zero test bit turns the following cycle into a discarded idle slot.
	a_skip_on_zero: assert property (@(posedge clk) disable iff (!resetn)
		(phase == q3 && op == test_bit_skip_if_zero_op && !data[bitsel])
		|-> ##3 (op == idle_slot) ##2 slot_discarded)
		else $error("Zero test bit did not discard the next instruction.");

	// A one test bit leaves the following instruction alone.
	a_no_skip_on_one: assert property (@(posedge clk) disable iff (!resetn)
		(phase == q3 && op == test_bit_skip_if_zero_op && data[bitsel])
		|-> ##3 (op != idle_slot))
		else $error("One test bit discarded the next instruction.");

	// Address and selector come from the decoded word.
	a_fields_taken: assert property (@(posedge clk) disable iff (!resetn)
		instr_taken |=> (rf_addr == $past(instr.addr) && bitsel == $past(instr.bitsel)))
		else $error("Address or bit selector not taken from the word.");

	// Quarters follow one another in ring order.
	a_quarter_ring: assert property (@(posedge clk) disable iff (!resetn)
		(phase == q1) |=> (phase == q2) ##1 (phase == q3) ##1 (phase == q4) ##1 (phase == q1))
		else $error("Quarter phases out of order.");

	// A read of a clear or set is followed two quarters later by its write.
	a_read_then_write: assert property (@(posedge clk) disable iff (!resetn)
		(rf_re && is_write_op) |-> (phase == q2) ##2 (rf_we && phase == q4))
		else $error("Read-modify-write did not finish in one cycle.");

	// The flags strobe never fires.
	a_flags_untouched: assert property (@(posedge clk) disable iff (!resetn)
		!status_we)
		else $error("Status flags written by a bit instruction.");

	// A word offered while a skip is pending is eaten, never taken.
	a_skip_eats_word: assert property (@(posedge clk) disable iff (!resetn)
		(phase == q1 && skip_pending) |-> !instr_taken)
		else $error("Word taken although a skip was pending.");

	// The test instruction only reads; its fourth quarter leaves the register alone.
	a_test_no_write: assert property (@(posedge clk) disable iff (!resetn)
		(phase == q4 && op == test_bit_skip_if_zero_op) |-> !rf_we)
		else $error("Test instruction wrote the register file.");

	// Write-back only ever happens in the fourth quarter.
	a_write_in_q4: assert property (@(posedge clk) disable iff (!resetn)
		rf_we |-> (phase == q4))
		else $error("Register write outside the fourth quarter.");

endmodule

// ==== verif/bit_op_instruction_unit_bench.sv ====
`timescale 1ns/1ps

// Drives instruction words and plays the register file read port by hand.
module bit_op_instruction_unit_bench;
	import bit_op_pkg::*;

	logic                clk;            // Core clock.
	logic                resetn;         // Synchronous reset, active low.
	instr_fields_t       instr;          // Word offered in q1.
	logic                instr_valid;    // Word present.
	logic [ADDR_W-1:0]   rf_addr;        // Register file address.
	logic                rf_re;          // Read strobe.
	logic [DATA_W-1:0]   rf_rdata;       // Read data from the bench.
	logic                rf_we;          // Write strobe.
	logic [DATA_W-1:0]   rf_wdata;       // Write data.
	logic                status_we;      // Flag write strobe.
	phase_t              phase;          // Current quarter.
	logic                instr_taken;    // Word accepted.
	logic                slot_discarded; // Idle slot marker.
	logic                skip_pending;   // Next slot will be eaten.
	int                  error_cnt;      // Mismatches seen.
	int                  cmp_count;      // Comparisons made.

	bit_op_instruction_unit dut_u (.clk(clk), .resetn(resetn), .instr(instr), .instr_valid(instr_valid),
		.rf_addr(rf_addr), .rf_re(rf_re), .rf_rdata(rf_rdata), .rf_we(rf_we), .rf_wdata(rf_wdata),
		.status_we(status_we), .phase(phase), .instr_taken(instr_taken),
		.slot_discarded(slot_discarded), .skip_pending(skip_pending));

	// Free-running 50 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Prints the verdict and stops the run.
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Case-equality compare, so an unknown never matches.
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Runs one instruction slot from q1 to q4 and judges every quarter.
	task automatic exec(input logic [3:0] opc, input logic [2:0] b, input logic [6:0] a, input logic [7:0] rd,
		input logic tk, input logic we, input logic disc, input logic sk, input logic [7:0] wd);
		int  n;
		logic re;
		n = 0;
		re = tk && (opc == OPC_CLEAR || opc == OPC_SET || opc == OPC_TEST);
		while (phase !== q1)
		begin
			@(negedge clk);
			n++;
			if (n > 8)
			begin
				error_cnt++;
				$display("Error phase expected q1 seen none");
				conclude();
			end
		end
		instr = '{opcode: opc, bitsel: b, addr: a};
		instr_valid = 1'b1;
		#1 chk("instr_taken", {7'h0, tk}, {7'h0, instr_taken});
		@(negedge clk);
		instr_valid = 1'b0;
		rf_rdata = rd;
		chk("rf_re", {7'h0, re}, {7'h0, rf_re});
		if (re)
			chk("rf_addr", {1'b0, a}, {1'b0, rf_addr});
		@(negedge clk);
		rf_rdata = ~rd;
		chk("rf_we q3", 8'h00, {7'h0, rf_we});
		@(negedge clk);
		rf_rdata = rd ^ 8'h5a;
		chk("rf_we", {7'h0, we}, {7'h0, rf_we});
		chk("phase", {6'h0, q4}, {6'h0, phase});
		if (we)
			chk("rf_wdata", wd, rf_wdata);
		chk("status_we", 8'h00, {7'h0, status_we});
		chk("slot_discarded", {7'h0, disc}, {7'h0, slot_discarded});
		chk("skip_pending", {7'h0, sk}, {7'h0, skip_pending});
	endtask

	// Clears each bit of a patterned byte at the top address.
	task automatic t_clear();
		for (int b = 0; b < 8; b++)
			exec(OPC_CLEAR, b[2:0], 7'h7f, 8'hc7, 1'b1, 1'b1, 1'b0, 1'b0, 8'hc7 & ~(BIT_ONE << b));
		$display("Test clear done");
	endtask

	// Sets each bit of a patterned byte at address zero.
	task automatic t_set();
		for (int b = 0; b < 8; b++)
			exec(OPC_SET, b[2:0], 7'h00, 8'h0a, 1'b1, 1'b1, 1'b0, 1'b0, 8'h0a | (BIT_ONE << b));
		$display("Test set done");
	endtask

	// Zero bit: the following set word is eaten and an idle slot runs.
	task automatic t_skip();
		exec(OPC_TEST, 3'h0, 7'h05, 8'hfe, 1'b1, 1'b0, 1'b0, 1'b1, 8'h00);
		exec(OPC_SET, 3'h3, 7'h05, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
		exec(OPC_CLEAR, 3'h1, 7'h06, 8'hff, 1'b1, 1'b1, 1'b0, 1'b0, 8'hfd);
		$display("Test skip done");
	endtask

	// One bit: no skip, the next word runs back to back.
	task automatic t_noskip();
		exec(OPC_TEST, 3'h7, 7'h40, 8'h80, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
		exec(OPC_SET, 3'h6, 7'h41, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0, 8'h40);
		exec(4'h0, 3'h2, 7'h12, 8'h33, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
		$display("Test no skip done");
	endtask

	// Main sequence: reset for six cycles, then every scenario.
	initial
	begin
		error_cnt = 0;
		cmp_count = 0;
		resetn = 1'b0;
		instr = '0;
		instr_valid = 1'b0;
		rf_rdata = 8'h00;
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		t_clear();
		t_set();
		t_skip();
		t_noskip();
		conclude();
	end
endmodule
